/* logic/lcg_pkg.sv */
// Package: constants and carriers for the DRAM command timing guard
package lcg_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int LINK_PERIOD_PS = 12000;
    // Termination and calibration timing, in ns
    localparam int TERM_DISABLE_NS = 12;
    localparam int TERM_ENABLE_NS = 12;
    localparam int CAL_RESULT_OUT_NS = 20;
    // Longest times round down, at least one cycle
    localparam int TERM_DISABLE_CYC = (TERM_DISABLE_NS * 1000) / LINK_PERIOD_PS < 1 ? 1 :
        (TERM_DISABLE_NS * 1000) / LINK_PERIOD_PS;
    localparam int TERM_ENABLE_CYC = (TERM_ENABLE_NS * 1000) / LINK_PERIOD_PS < 1 ? 1 :
        (TERM_ENABLE_NS * 1000) / LINK_PERIOD_PS;
    localparam int CAL_RESULT_CYC = (CAL_RESULT_OUT_NS * 1000) / LINK_PERIOD_PS < 1 ? 1 :
        (CAL_RESULT_OUT_NS * 1000) / LINK_PERIOD_PS;
    // Read turnaround: off one cycle before data, on one after
    localparam int AUTO_TERM_OFF_LEAD = 1;
    localparam int AUTO_TERM_ON_LAG = 1;

    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_ACT = 4'h1;
    localparam logic [3:0] CMD_READ = 4'h2;
    localparam logic [3:0] CMD_MRW = 4'h3;
    localparam logic [3:0] CMD_PDE = 4'h4;
    localparam logic [3:0] CMD_SRE = 4'h5;
    localparam logic [3:0] CMD_DPDE = 4'h6;
    localparam logic [3:0] CMD_CAL = 4'h7;
    localparam logic [7:0] MR_CAL_ENTER = 8'h29;
    localparam logic [7:0] MR_CAL_EXIT = 8'h2a;

    typedef enum logic [2:0] {
        LCG_ACTIVE = 3'b000,
        LCG_PD = 3'b001,
        LCG_SR = 3'b010,
        LCG_DPD = 3'b011,
        LCG_CAL = 3'b100
    } lcg_state_e;

    typedef struct packed {
        logic [3:0] op;
        logic [7:0] arg;
    } lcg_cmd_s;
endpackage

/* logic/lcg_delay.sv */
// Countdown timer: whoever acts on the pulse lands count cycles after start, or one cycle for a count of zero
`timescale 1ns/10ps
module lcg_delay
    import lcg_pkg::*;
#(
    parameter int W = 6
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] cnt;
    logic busy;
    // Pulse leads by one cycle so that its registered consumer is on time
    // Counts of zero and one both land one cycle after start
    wire logic short_run = start_i && (count_i <= W'(1));
    wire logic last = busy && (cnt == W'(2));

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            busy <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= short_run || (last && !start_i);
            if (start_i)
            begin
                cnt <= count_i;
                busy <= !short_run;
            end
            else if (busy)
            begin
                cnt <= cnt - W'(1);
                busy <= !last;
            end
        end
    end
endmodule

/* logic/lcg_guard.sv */
// Device-side timing guard: termination control and calibration echo
`timescale 1ns/10ps
// Contract
// - Termination off within 12 ns of power-down.
// - Termination off after self-refresh or deep power-down.
// - Termination on within 12 ns after exit; the code skips deep power-down exit.
// - Termination back on soon after read data.
// - Termination off not too early before read.
// - Calibration pattern on data within 20 ns.
module lcg_guard
    import lcg_pkg::*;
#(
    parameter int READ_LATENCY = 12,
    parameter int DATA_W = 8
)(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic link_cke_i,
    input wire logic link_cmd_valid_i,
    input wire lcg_cmd_s link_cmd_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic termination_resistance_o,
    output logic [2:0] power_state_o,
    output logic cal_mode_o
);
    // ------------------------------------------------------------
    // Link domain: command decode
    // ------------------------------------------------------------
    // Reset is synchronised into the link domain by release only
    logic lrst_m;
    logic lrst;
    always_ff @(posedge link_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lrst_m <= 1'b1;
            lrst <= 1'b1;
        end
        else
        begin
            lrst_m <= 1'b0;
            lrst <= lrst_m;
        end
    end

    lcg_state_e state;
    lcg_state_e next_state;
    logic cke_d;
    logic term;
    logic [DATA_W-1:0] cal_pat;
    logic [DATA_W-1:0] dq_l;
    logic dq_oe_l;
    logic [READ_LATENCY+1:0] rd_pipe;

    wire logic cmd_v = link_cmd_valid_i && link_cke_i;
    wire logic is_pde = cmd_v && link_cmd_i.op == CMD_PDE && state == LCG_ACTIVE;
    wire logic is_sre = cmd_v && link_cmd_i.op == CMD_SRE && state == LCG_ACTIVE;
    wire logic is_dpde = cmd_v && link_cmd_i.op == CMD_DPDE && state == LCG_ACTIVE;
    wire logic is_read = cmd_v && link_cmd_i.op == CMD_READ && state == LCG_ACTIVE;
    wire logic is_cal_in = cmd_v && link_cmd_i.op == CMD_MRW && link_cmd_i.arg == MR_CAL_ENTER;
    wire logic is_cal_out = cmd_v && link_cmd_i.op == CMD_MRW && link_cmd_i.arg == MR_CAL_EXIT;
    // Calibration commands arrive with clock-enable low
    wire logic is_cal_cmd = link_cmd_valid_i && state == LCG_CAL && link_cmd_i.op == CMD_CAL;
    wire logic cke_rise = link_cke_i && !cke_d;
    wire logic leave_low = cke_rise && (state == LCG_PD || state == LCG_SR);
    wire logic enter_low = is_pde || is_sre || is_dpde;
    wire logic rd_start = rd_pipe[READ_LATENCY - AUTO_TERM_OFF_LEAD];
    wire logic rd_end = rd_pipe[READ_LATENCY + AUTO_TERM_ON_LAG];

    always_comb
    begin
        next_state = state;
        case (state)
            LCG_ACTIVE:
            begin
                if (is_pde)
                    next_state = LCG_PD;
                else if (is_sre)
                    next_state = LCG_SR;
                else if (is_dpde)
                    next_state = LCG_DPD;
                else if (is_cal_in)
                    next_state = LCG_CAL;
            end
            LCG_PD, LCG_SR, LCG_DPD:
            begin
                // Deep power-down exit relies on controller residency
                if (cke_rise)
                    next_state = LCG_ACTIVE;
            end
            LCG_CAL:
            begin
                if (is_cal_out)
                    next_state = LCG_ACTIVE;
            end
            default: next_state = LCG_ACTIVE;
        endcase
    end

    // Termination turn-off and turn-on timers
    logic off_done;
    logic on_done;
    lcg_delay #(.W(6)) u_off (
        .clk_i(link_clk_i),
        .rst_i(lrst),
        .start_i(enter_low),
        .count_i(6'(TERM_DISABLE_CYC)),
        .done_o(off_done)
    );
    lcg_delay #(.W(6)) u_on (
        .clk_i(link_clk_i),
        .rst_i(lrst),
        .start_i(leave_low),
        .count_i(6'(TERM_ENABLE_CYC)),
        .done_o(on_done)
    );
    // Calibration echo timer
    logic cal_done;
    lcg_delay #(.W(6)) u_cal (
        .clk_i(link_clk_i),
        .rst_i(lrst),
        .start_i(is_cal_cmd),
        .count_i(6'(CAL_RESULT_CYC)),
        .done_o(cal_done)
    );

    always_ff @(posedge link_clk_i or posedge lrst)
    begin
        if (lrst)
        begin
            state <= LCG_ACTIVE;
            cke_d <= 1'b1;
            term <= 1'b1;
            cal_pat <= '0;
            dq_l <= '0;
            dq_oe_l <= 1'b0;
            rd_pipe <= '0;
        end
        else
        begin
            state <= next_state;
            cke_d <= link_cke_i;
            rd_pipe <= {rd_pipe[READ_LATENCY:0], is_read};
            // Off inside the window after power-down or self-refresh entry
            if (off_done)
                term <= 1'b0;
            else if (on_done)
                term <= 1'b1;
            else if (rd_start)
                term <= 1'b0;
            else if (rd_end && state == LCG_ACTIVE)
                term <= 1'b1;
            if (is_cal_cmd)
                cal_pat <= link_cmd_i.arg[DATA_W-1:0];
            if (cal_done)
            begin
                dq_l <= cal_pat;
                dq_oe_l <= 1'b1;
            end
            else if (is_cal_out)
                dq_oe_l <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Crossing into the system clock domain
    // ------------------------------------------------------------
    // Level status only; pattern word is sampled when stable
    // Third stage drops torn multi-bit captures: a word is passed on only
    // after two equal samples, so levels shorter than that are lost
    logic [5:0] s_m;
    logic [5:0] s_q;
    logic [5:0] s_r;
    logic [DATA_W-1:0] dq_m;
    logic [DATA_W-1:0] dq_q;
    logic [DATA_W-1:0] dq_r;
    wire logic steady = (s_q == s_r) && (dq_q == dq_r);
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_m <= {1'b1, LCG_ACTIVE, 1'b0, 1'b0};
            s_q <= {1'b1, LCG_ACTIVE, 1'b0, 1'b0};
            s_r <= {1'b1, LCG_ACTIVE, 1'b0, 1'b0};
            dq_m <= '0;
            dq_q <= '0;
            dq_r <= '0;
        end
        else
        begin
            s_m <= {term, state, dq_oe_l, (state == LCG_CAL)};
            s_q <= s_m;
            s_r <= s_q;
            dq_m <= dq_l;
            dq_q <= dq_m;
            dq_r <= dq_q;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dq_o <= '0;
            dq_oe_o <= 1'b0;
            termination_resistance_o <= 1'b1;
            power_state_o <= LCG_ACTIVE;
            cal_mode_o <= 1'b0;
        end
        else if (steady)
        begin
            termination_resistance_o <= s_r[5];
            power_state_o <= s_r[4:2];
            dq_oe_o <= s_r[1];
            cal_mode_o <= s_r[0];
            dq_o <= dq_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_term_off_pd: assert property (@(posedge link_clk_i) disable iff (lrst)
        is_pde |-> ##[1:2] !term)
        else $error("termination not off after power-down");
    a_term_off_sr: assert property (@(posedge link_clk_i) disable iff (lrst)
        (is_sre || is_dpde) |-> ##[1:2] !term)
        else $error("termination not off after self-refresh");
    a_term_on_exit: assert property (@(posedge link_clk_i) disable iff (lrst)
        leave_low |-> ##[1:2] term)
        else $error("termination not on after exit");
    a_read_term_off: assert property (@(posedge link_clk_i) disable iff (lrst)
        (is_read && state == LCG_ACTIVE) |-> ##[1:30] !term)
        else $error("termination not off for read");
    a_read_term_on: assert property (@(posedge link_clk_i) disable iff (lrst)
        $rose(rd_end) && state == LCG_ACTIVE && !enter_low |=> term)
        else $error("termination not back on after read");
    a_cal_echo_time: assert property (@(posedge link_clk_i) disable iff (lrst)
        is_cal_cmd |-> ##2 (dq_oe_l && dq_l == $past(link_cmd_i.arg[DATA_W-1:0], 2)))
        else $error("calibration pattern late");
endmodule

/* verification/lcg_ctrl_model.sv */
// Memory controller model driving link commands with legal spacing
`timescale 1ns/10ps
module lcg_ctrl_model
    import lcg_pkg::*;
(
    input wire logic link_clk_i,
    output logic link_cke_o,
    output logic link_cmd_valid_o,
    output lcg_cmd_s link_cmd_o
);
    // Larger of a rounded-up time and a cycle count
    function automatic int tmax(input int ps, input int n);
        int c;
        c = (ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
        return c > n ? c : n;
    endfunction
    localparam int RRD_CYC = tmax(10000, 2);
    localparam int FAW_CYC = tmax(50000, 8);
    localparam int DPD_MIN_CYC = tmax(500000000, 0);
    localparam int MRW_CYC = 4;
    localparam int CAL_GAP = 10;
    localparam int CAL_ENTRY = 20;
    int cyc = 0;
    int act_t[4] = '{-99, -99, -99, -99};
    initial
    begin
        link_cke_o = 1'b1;
        link_cmd_valid_o = 1'b0;
        link_cmd_o = '0;
    end
    always @(posedge link_clk_i) cyc <= cyc + 1;
    task automatic tick(input int n);
        repeat (n) @(posedge link_clk_i);
        #1;
    endtask
    task automatic issue(input logic [3:0] op, input logic [7:0] arg);
        tick(1);
        link_cmd_valid_o = 1'b1;
        link_cmd_o = '{op: op, arg: arg};
        tick(1);
        link_cmd_valid_o = 1'b0;
        // Released bus must not keep showing the last command
        link_cmd_o = ~link_cmd_o;
        if (op == CMD_MRW)
            tick(MRW_CYC - 1);
    endtask
    task automatic act(input logic [7:0] bank);
        while (cyc + 2 - act_t[0] < FAW_CYC) tick(1);
        issue(CMD_ACT, bank);
        act_t = '{act_t[1], act_t[2], act_t[3], cyc};
        tick(RRD_CYC - 1);
    endtask
    task automatic sleep(input logic [3:0] op);
        issue(op, 8'h00);
        link_cke_o = 1'b0;
    endtask
    task automatic wake();
        tick(1);
        link_cke_o = 1'b1;
        tick(4);
    endtask
    task automatic cal_enter();
        issue(CMD_MRW, MR_CAL_ENTER);
        tick(CAL_GAP);
        link_cke_o = 1'b0;
        tick(CAL_ENTRY - CAL_GAP);
    endtask
    task automatic cal_exit();
        // Margin for the echo still crossing domains
        tick(CAL_GAP + 4);
        link_cke_o = 1'b1;
        tick(CAL_GAP);
        issue(CMD_MRW, MR_CAL_EXIT);
    endtask
endmodule

/* verification/lcg_guard_tb_top.sv */
// Testbench for the DRAM command timing guard
`timescale 1ns/10ps
module lcg_guard_tb_top import lcg_pkg::*;;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic cke, vld, oe, term, cal;
    lcg_cmd_s cmd;
    logic [7:0] dq;
    logic [2:0] pstate;
    int fail_count = 0;
    int check_count = 0;
    always #4 mclk = ~mclk;
    always #6 link_clk = ~link_clk;
    lcg_ctrl_model mdl (.link_clk_i(link_clk), .link_cke_o(cke), .link_cmd_valid_o(vld), .link_cmd_o(cmd));
    lcg_guard dut (.mclk_i(mclk), .rst_i(rst), .link_clk_i(link_clk), .link_cke_i(cke),
        .link_cmd_valid_i(vld), .link_cmd_i(cmd), .dq_o(dq), .dq_oe_o(oe),
        .termination_resistance_o(term), .power_state_o(pstate), .cal_mode_o(cal));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] probe(input int sel);
        case (sel)
            0: return {7'h00, term};
            1: return {7'h00, oe};
            2: return dq;
            3: return {5'h00, pstate};
            default: return {7'h00, cal};
        endcase
    endfunction
    // Bounded wait on a registered output, then compare
    task automatic await(input int sel, input logic [7:0] exp);
        int n;
        n = 0;
        while (probe(sel) !== exp && n < 12)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(probe(sel), exp);
    endtask
    task automatic t_reset();
        chk(term, 1'b1);
        chk(oe, 1'b0);
        chk(dq, 8'h00);
        chk(pstate, LCG_ACTIVE);
        chk(cal, 1'b0);
    endtask
    task automatic t_acts();
        for (int b = 0; b < 5; b++)
            mdl.act(8'(b));
        await(3, LCG_ACTIVE);
        chk(term, 1'b1);
    endtask
    task automatic t_read();
        mdl.issue(CMD_READ, 8'h00);
        repeat (14) @(posedge mclk);
        #1;
        chk(term, 1'b1);
        await(0, 8'h00);
        await(0, 8'h01);
    endtask
    task automatic t_power(input logic [3:0] op, input lcg_state_e st, input int hold);
        mdl.sleep(op);
        await(0, 8'h00);
        chk(pstate, st);
        mdl.tick(hold);
        mdl.wake();
        if (op != CMD_DPDE)
            await(0, 8'h01);
        await(3, LCG_ACTIVE);
    endtask
    task automatic t_cal();
        logic [7:0] pat[2] = '{8'h3c, 8'hc3};
        mdl.cal_enter();
        chk(cal, 1'b1);
        chk(pstate, LCG_CAL);
        foreach (pat[i])
        begin
            mdl.issue(CMD_CAL, pat[i]);
            await(2, pat[i]);
            chk(oe, 1'b1);
        end
        mdl.cal_exit();
        await(1, 8'h00);
        await(4, 8'h00);
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Deep power-down residency dominates the run time
    initial
    begin
        #600000;
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        mdl.tick(6);
        t_reset();
        t_acts();
        t_read();
        t_power(CMD_PDE, LCG_PD, 4);
        t_power(CMD_SRE, LCG_SR, 4);
        t_cal();
        t_power(CMD_DPDE, LCG_DPD, mdl.DPD_MIN_CYC);
        summarize();
    end
endmodule
